/* File: rtl/lnf_pkg.sv */
// How it works
// - Node ID is bus number plus node number
// - Valid flag clears on reset, sets on node
// - Root flag follows PHY root report while bus reset is high
// - Cable power bit follows PHY report
// - Node number loaded from PHY after self-ID
// - Reserved bits read as zero
// - Read-complete clears when a request set
// - PHY return stores address, data, sets complete
// - Request bit starts PHY request, clears sent
// - Address field targets register, byte for writes
// - Master sends timer, else loads from start
// - Timer free-runs when enabled without starts
// - Offset counts modulo 3072, wrap is cycle
// - Count modulo 8000, seconds modulo 128
// - External 8 kHz tick zeroes offset
// - Local source needs its filter bit
// - Remote accepted only with accept-all bit
// - Node N maps to low or high bit
// - Bus reset clears per-node bits only
// - Filter writes ignored during bus reset flag
package lnf_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_NODE_ID   = 12'h0E8;
  localparam logic [11:0] OFS_PHY_ACC   = 12'h0EC;
  localparam logic [11:0] OFS_CYC_TMR   = 12'h0F0;
  localparam logic [11:0] OFS_FHI_SET   = 12'h100;
  localparam logic [11:0] OFS_FHI_CLR   = 12'h104;
  localparam logic [11:0] OFS_FLO_SET   = 12'h108;
  localparam logic [11:0] OFS_FLO_CLR   = 12'h10C;
  localparam logic [11:0] OFS_LINK_CTL  = 12'h120;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int NID_VALID_BIT  = 31;
  localparam int NID_ROOT_BIT   = 30;
  localparam int NID_CPS_BIT    = 27;
  localparam int PHY_DONE_BIT   = 31;
  localparam int PHY_RD_BIT     = 15;
  localparam int PHY_WR_BIT     = 14;
  localparam int FHI_ALL_BIT    = 31;
  localparam int LCTL_MASTER_BIT = 1;
  localparam int LCTL_ENABLE_BIT = 0;
  localparam int LCTL_EXT_BIT   = 2;
  localparam int LCTL_BRST_BIT  = 3;
  // ----------------------------------------
  // Reset values and timer moduli
  // ----------------------------------------
  localparam logic [9:0]  BUS_NUM_RST   = 10'h3FF;
  localparam logic [5:0]  NODE_NUM_RST  = 6'h3F;
  localparam logic [11:0] OFFSET_MAX    = 12'hBFF;  // 3072 - 1
  localparam logic [12:0] CYCLE_MAX     = 13'h1F3F; // 8000 - 1
  localparam logic [6:0]  SECONDS_MAX   = 7'h7F;    // 128 - 1
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {PHY_IDLE, PHY_BUSY} lnf_phy_st_t;
endpackage

/* File: rtl/lnf_regs.sv */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
module lnf_regs (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // PHY core status (asynchronous)
  input  wire logic        phy_bus_reset,
  input  wire logic        phy_self_id_done,
  input  wire logic [5:0]  phys_node_number,
  input  wire logic        phy_is_root,
  input  wire logic        cable_power_ok,
  // PHY register request / answer
  output logic             phy_req_valid,
  output logic             phy_req_write,
  output logic [3:0]       phy_req_addr,
  output logic [7:0]       phy_req_data,
  input  wire logic        phy_req_ack,
  input  wire logic        phy_ret_valid,
  input  wire logic [3:0]  phy_returned_address,
  input  wire logic [7:0]  phy_returned_data,
  // Cycle timer events (asynchronous)
  input  wire logic        cyc_tick_24m,
  input  wire logic        ext_tick_8k,
  input  wire logic        cyc_start_rx,
  input  wire logic [31:0] cyc_start_data,
  output logic [31:0]      cycle_timer,
  // Request filter lookup
  input  wire logic        flt_query,
  input  wire logic [9:0]  flt_src_bus,
  input  wire logic [5:0]  flt_src_node,
  output logic             flt_accept,
  output logic [15:0]      node_id
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] sy1_r;
  logic [NSYNC-1:0] sy2_r;
  logic [NSYNC-1:0] syp_r;

  // Two-stage capture of pin-side inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_r <= '0;
      sy2_r <= '0;
      syp_r <= '0;
    end else begin
      sy1_r <= {phy_bus_reset, phy_self_id_done, phys_node_number, phy_is_root,
                cable_power_ok, phy_req_ack, phy_ret_valid, cyc_tick_24m,
                ext_tick_8k, cyc_start_rx, flt_query};
      sy2_r <= sy1_r;
      syp_r <= sy2_r;
    end
  end

  logic       s_brst, s_sid, s_root, s_cps, s_ack, s_ret, s_tick, s_ext, s_cs, s_q;
  logic [5:0] s_node;
  assign s_brst = sy2_r[15];
  assign s_sid  = sy2_r[14];
  assign s_node = sy2_r[13:8];
  assign s_root = sy2_r[7];
  assign s_cps  = sy2_r[6];
  assign s_ack  = sy2_r[5];
  assign s_ret  = sy2_r[4];
  assign s_tick = sy2_r[3];
  assign s_ext  = sy2_r[2];
  assign s_cs   = sy2_r[1];
  assign s_q    = sy2_r[0];

  // Rising-edge events from synchronised levels
  logic e_brst, e_sid, e_ack, e_ret, e_tick, e_ext, e_cs, e_q;
  assign e_brst = s_brst & ~syp_r[15];
  assign e_sid  = s_sid  & ~syp_r[14];
  assign e_ack  = s_ack  & ~syp_r[5];
  assign e_ret  = s_ret  & ~syp_r[4];
  assign e_tick = s_tick & ~syp_r[3];
  assign e_ext  = s_ext  & ~syp_r[2];
  assign e_cs   = s_cs   & ~syp_r[1];
  assign e_q    = s_q    & ~syp_r[0];

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic        aw_have_r, w_have_r;
  logic        wr_fire;
  assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a[11:2] == o[11:2];
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return hit(a, lnf_pkg::OFS_NODE_ID) | hit(a, lnf_pkg::OFS_PHY_ACC) |
           hit(a, lnf_pkg::OFS_CYC_TMR) | hit(a, lnf_pkg::OFS_FHI_SET) |
           hit(a, lnf_pkg::OFS_FHI_CLR) | hit(a, lnf_pkg::OFS_FLO_SET) |
           hit(a, lnf_pkg::OFS_FLO_CLR) | hit(a, lnf_pkg::OFS_LINK_CTL);
  endfunction

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lnf_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_r) ? lnf_pkg::RESP_OKAY : lnf_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_nid, wr_phy, wr_cyc, wr_hs, wr_hc, wr_ls, wr_lc, wr_ctl;
  assign wr_nid = wr_fire & hit(awaddr_r, lnf_pkg::OFS_NODE_ID);
  assign wr_phy = wr_fire & hit(awaddr_r, lnf_pkg::OFS_PHY_ACC);
  assign wr_cyc = wr_fire & hit(awaddr_r, lnf_pkg::OFS_CYC_TMR);
  assign wr_hs  = wr_fire & hit(awaddr_r, lnf_pkg::OFS_FHI_SET);
  assign wr_hc  = wr_fire & hit(awaddr_r, lnf_pkg::OFS_FHI_CLR);
  assign wr_ls  = wr_fire & hit(awaddr_r, lnf_pkg::OFS_FLO_SET);
  assign wr_lc  = wr_fire & hit(awaddr_r, lnf_pkg::OFS_FLO_CLR);
  assign wr_ctl = wr_fire & hit(awaddr_r, lnf_pkg::OFS_LINK_CTL);

  // ----------------------------------------
  // Link control (master, enable, ext ref, reset flag)
  // ----------------------------------------
  logic [3:0] lctl_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lctl_r <= 4'h0;
    end else begin
      lctl_r[2:0] <= wr_ctl ? wdata_r[2:0] : lctl_r[2:0];
      if (e_brst) begin
        lctl_r[lnf_pkg::LCTL_BRST_BIT] <= 1'b1;  // Set wins over clear
      end else if (wr_ctl && wdata_r[lnf_pkg::LCTL_BRST_BIT]) begin
        lctl_r[lnf_pkg::LCTL_BRST_BIT] <= 1'b0;  // Write one to clear
      end
    end
  end
  logic brst_flag;
  assign brst_flag = lctl_r[lnf_pkg::LCTL_BRST_BIT];

  // ----------------------------------------
  // Node identity
  // ----------------------------------------
  logic       valid_r, root_r, cps_r;
  logic [9:0] busnum_r;
  logic [5:0] nodenum_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_r   <= 1'b0;
      root_r    <= 1'b0;
      cps_r     <= 1'b0;
      busnum_r  <= lnf_pkg::BUS_NUM_RST;
      nodenum_r <= lnf_pkg::NODE_NUM_RST;
    end else begin
      cps_r <= s_cps;
      if (s_brst) begin
        root_r <= s_root;
      end
      if (e_sid) begin
        nodenum_r <= s_node;
        valid_r   <= 1'b1;
      end else if (e_brst) begin
        valid_r <= 1'b0;
      end
      if (wr_nid) begin
        busnum_r <= wdata_r[15:6];
      end
    end
  end

  logic [31:0] nid_word;
  // Reserved bits tied low
  assign nid_word = {valid_r, root_r, 2'b00, cps_r, 11'h000, busnum_r, nodenum_r};

  // ----------------------------------------
  // PHY register access
  // ----------------------------------------
  lnf_pkg::lnf_phy_st_t phy_st;
  logic       rdreq_r, wrreq_r, done_r;
  logic [3:0] tgt_r, raddr_r;
  logic [7:0] wbyte_r, rdata_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_st        <= lnf_pkg::PHY_IDLE;
      rdreq_r       <= 1'b0;
      wrreq_r       <= 1'b0;
      done_r        <= 1'b0;
      tgt_r         <= 4'h0;
      wbyte_r       <= 8'h00;
      raddr_r       <= 4'h0;
      rdata_r       <= 8'h00;
      phy_req_valid <= 1'b0;
      phy_req_write <= 1'b0;
      phy_req_addr  <= 4'h0;
      phy_req_data  <= 8'h00;
    end else begin
      if (e_ret) begin
        raddr_r <= phy_returned_address;
        rdata_r <= phy_returned_data;
        done_r  <= 1'b1;
      end else if (wr_phy && (wdata_r[lnf_pkg::PHY_RD_BIT] || wdata_r[lnf_pkg::PHY_WR_BIT])) begin
        done_r <= 1'b0;
      end
      case (phy_st)
        lnf_pkg::PHY_IDLE: begin
          if (wr_phy) begin
            tgt_r   <= wdata_r[11:8];
            wbyte_r <= wdata_r[7:0];
            rdreq_r <= wdata_r[lnf_pkg::PHY_RD_BIT];
            wrreq_r <= wdata_r[lnf_pkg::PHY_WR_BIT] & ~wdata_r[lnf_pkg::PHY_RD_BIT];
          end else if (rdreq_r || wrreq_r) begin
            phy_req_valid <= 1'b1;
            phy_req_write <= wrreq_r;
            phy_req_addr  <= tgt_r;
            phy_req_data  <= wrreq_r ? wbyte_r : 8'h00;
            phy_st        <= lnf_pkg::PHY_BUSY;
          end
        end
        lnf_pkg::PHY_BUSY: begin
          if (e_ack) begin
            phy_req_valid <= 1'b0;
            rdreq_r       <= 1'b0;
            wrreq_r       <= 1'b0;
            phy_st        <= lnf_pkg::PHY_IDLE;
          end
        end
        default: phy_st <= lnf_pkg::PHY_IDLE;
      endcase
    end
  end

  logic [31:0] phy_word;
  assign phy_word = {done_r, 3'b000, raddr_r, rdata_r, rdreq_r, wrreq_r, 2'b00,
                     tgt_r, wbyte_r};

  // ----------------------------------------
  // Cycle timer
  // ----------------------------------------
  logic [6:0]  sec_r;
  logic [12:0] cnt_r;
  logic [11:0] off_r;
  logic        owrap, cwrap;
  assign owrap = (off_r == lnf_pkg::OFFSET_MAX);
  assign cwrap = (cnt_r == lnf_pkg::CYCLE_MAX);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_r <= 7'h00;
      cnt_r <= 13'h0000;
      off_r <= 12'h000;
    end else if (wr_cyc) begin
      {sec_r, cnt_r, off_r} <= wdata_r;
    end else if (e_cs && !lctl_r[lnf_pkg::LCTL_MASTER_BIT]) begin
      {sec_r, cnt_r, off_r} <= cyc_start_data;
    end else if (lctl_r[lnf_pkg::LCTL_EXT_BIT] && e_ext) begin
      off_r <= 12'h000;
    end else if (lctl_r[lnf_pkg::LCTL_ENABLE_BIT] && e_tick) begin
      off_r <= owrap ? 12'h000 : off_r + 12'h001;
      if (owrap) begin
        cnt_r <= cwrap ? 13'h0000 : cnt_r + 13'h0001;
        if (cwrap) begin
          sec_r <= (sec_r == lnf_pkg::SECONDS_MAX) ? 7'h00 : sec_r + 7'h01;
        end
      end
    end
  end

  // Timer value offered to the cycle start sender
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycle_timer <= '0;
    end else begin
      cycle_timer <= {sec_r, cnt_r, off_r};
    end
  end

  // ----------------------------------------
  // Asynchronous request filters
  // ----------------------------------------
  logic [31:0] fhi_r, flo_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fhi_r <= 32'h0000_0000;
      flo_r <= 32'h0000_0000;
    end else if (e_brst) begin
      fhi_r <= {fhi_r[lnf_pkg::FHI_ALL_BIT], 31'h0};
      flo_r <= 32'h0000_0000;
    end else if (!brst_flag) begin
      if (wr_hs) fhi_r <= fhi_r | wdata_r;
      if (wr_hc) fhi_r <= fhi_r & ~wdata_r;
      if (wr_ls) flo_r <= flo_r | wdata_r;
      if (wr_lc) flo_r <= flo_r & ~wdata_r;
    end
  end

  // Lookup of one incoming request's source
  logic       node_bit;
  logic [9:0] q_bus;
  logic [5:0] q_node;
  assign q_bus  = flt_src_bus;
  assign q_node = flt_src_node;
  assign node_bit = q_node[5] ? fhi_r[q_node[4:0]] & (q_node[4:0] != 5'h1F)
                              : flo_r[q_node[4:0]];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_accept <= 1'b0;
      node_id    <= 16'h0000;
    end else begin
      node_id <= {busnum_r, nodenum_r};
      if (e_q) begin
        if (q_bus == busnum_r || q_bus == lnf_pkg::BUS_NUM_RST) begin
          flt_accept <= node_bit;
        end else begin
          flt_accept <= fhi_r[lnf_pkg::FHI_ALL_BIT];
        end
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= lnf_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? lnf_pkg::RESP_OKAY : lnf_pkg::RESP_SLVERR;
        if (hit(s_axi_araddr, lnf_pkg::OFS_NODE_ID))       s_axi_rdata <= nid_word;
        else if (hit(s_axi_araddr, lnf_pkg::OFS_PHY_ACC))  s_axi_rdata <= phy_word;
        else if (hit(s_axi_araddr, lnf_pkg::OFS_CYC_TMR))  s_axi_rdata <= {sec_r, cnt_r, off_r};
        else if (hit(s_axi_araddr, lnf_pkg::OFS_FHI_SET) ||
                 hit(s_axi_araddr, lnf_pkg::OFS_FHI_CLR))  s_axi_rdata <= fhi_r;
        else if (hit(s_axi_araddr, lnf_pkg::OFS_FLO_SET) ||
                 hit(s_axi_araddr, lnf_pkg::OFS_FLO_CLR))  s_axi_rdata <= flo_r;
        else if (hit(s_axi_araddr, lnf_pkg::OFS_LINK_CTL)) s_axi_rdata <= {28'h0, lctl_r};
        else                                               s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: tb/lnf_regs_properties.sv */
`timescale 1ns/10ps
module lnf_regs_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus responses
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // PHY request and timer
  input wire logic        phy_req_valid,
  input wire logic        phy_req_write,
  input wire logic [3:0]  phy_req_addr,
  input wire logic [7:0]  phy_req_data,
  input wire logic        phy_req_ack,
  input wire logic [31:0] cycle_timer
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // PHY request handshake
  // ----------------------------------------
  sequence s_ack_rise;
    $rose(phy_req_ack);
  endsequence
  sequence s_req_drop;
    ##[1:6] !phy_req_valid;
  endsequence
  property p_req_hold;
    phy_req_valid && !phy_req_ack |=> phy_req_valid;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("PHY request dropped early");
  property p_req_clear;
    s_ack_rise |-> s_req_drop;
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("PHY request not cleared");
  property p_req_stable;
    phy_req_valid && $past(phy_req_valid) |-> $stable({phy_req_write, phy_req_addr, phy_req_data});
  endproperty
  a_req_stable: assert property (p_req_stable) else $error("PHY request changed");
  // ----------------------------------------
  // Timer field ranges
  // ----------------------------------------
  property p_offset_range;
    cycle_timer[11:0] <= lnf_pkg::OFFSET_MAX;
  endproperty
  a_offset_range: assert property (p_offset_range) else $error("Offset out of range");
  property p_count_range;
    cycle_timer[24:12] <= lnf_pkg::CYCLE_MAX;
  endproperty
  a_count_range: assert property (p_count_range) else $error("Cycle count out of range");
  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  property p_ar_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("Read answer late");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("Read answer not held");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("Write answer not held");
endmodule
bind lnf_regs lnf_regs_properties u_lnf_regs_properties (.*);

/* File: tb/lnf_phy_model.sv */
`timescale 1ns/10ps
module lnf_phy_model #(
  parameter int ACK_DLY = 2
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Request from the link
  input  wire logic       phy_req_valid,
  input  wire logic       phy_req_write,
  input  wire logic [3:0] phy_req_addr,
  input  wire logic [7:0] phy_req_data,
  // Answer to the link
  output logic            phy_req_ack,
  output logic            phy_ret_valid,
  output logic [3:0]      phy_returned_address,
  output logic [7:0]      phy_returned_data
);
  logic [7:0] regs [16];
  // Serve one register request at a time
  initial begin
    logic [3:0] a;
    logic       w;
    for (int i = 0; i < 16; i++) regs[i] = 8'h10 + 8'(i);
    phy_req_ack = 1'b0;
    phy_ret_valid = 1'b0;
    phy_returned_address = 4'hF;
    phy_returned_data = 8'hFF;
    forever begin
      @(posedge aclk);
      if (aresetn && phy_req_valid) begin
        repeat (ACK_DLY) @(posedge aclk);
        a = phy_req_addr;
        w = phy_req_write;
        if (w) regs[a] = phy_req_data;
        phy_req_ack <= 1'b1;
        for (int n = 0; n < 64 && phy_req_valid; n++) @(posedge aclk);
        phy_req_ack <= 1'b0;
        if (!w) begin
          phy_returned_address <= a;
          phy_returned_data <= regs[a];
          @(posedge aclk);
          phy_ret_valid <= 1'b1;
          repeat (4) @(posedge aclk);
          phy_ret_valid <= 1'b0;
          @(posedge aclk);
          // Released lines stop showing the old value
          phy_returned_address <= ~phy_returned_address;
          phy_returned_data <= ~phy_returned_data;
        end
      end
    end
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, phy_bus_reset, phy_self_id_done, phy_is_root, cable_power_ok;
  logic        phy_req_valid, phy_req_write, phy_req_ack, phy_ret_valid, flt_accept;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb, phy_req_addr, phy_returned_address, ev;
  logic [5:0]  phys_node_number, flt_src_node;
  logic [7:0]  phy_req_data, phy_returned_data;
  logic [9:0]  flt_src_bus;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] node_id;
  logic [31:0] s_axi_wdata, s_axi_rdata, cyc_start_data, cycle_timer;
  wire         cyc_tick_24m = ev[0];
  wire         ext_tick_8k  = ev[1];
  wire         cyc_start_rx = ev[2];
  wire         flt_query    = ev[3];
  int          bad_count, total_checks;
  logic [31:0] d;
  logic [1:0]  r;

  lnf_regs u_lnf_regs (.*);
  lnf_phy_model #(.ACK_DLY(3)) u_lnf_phy_model (.*);

  // Clock
  always #20 aclk = ~aclk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n > 60) begin
      bad_count++;
      $display("ERROR %0t wait limit reached", $time);
      complete_run();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    int   n;
    logic ta, tw;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      guard(n++);
      if (s_axi_awready && !ta) s_axi_awvalid <= 1'b0;
      if (s_axi_awready) ta = 1'b1;
      if (s_axi_wready && !tw) s_axi_wvalid <= 1'b0;
      if (s_axi_wready) tw = 1'b1;
    end
    // Late ready makes the slave hold its answer
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n++);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, lnf_pkg::RESP_OKAY});
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n++);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n++);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    axr(a, d, r);
    chk(d, e);
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      axr(lnf_pkg::OFS_PHY_ACC, d, r);
      guard(n++);
    end while ((d & m) !== v);
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    repeat (3) @(posedge aclk);
    ev[k] <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic qry(input logic [9:0] b, input logic [5:0] nd, input logic e);
    flt_src_bus <= b;
    flt_src_node <= nd;
    pulse(3);
    chk({31'h0, flt_accept}, {31'h0, e});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {phy_bus_reset, phy_self_id_done, phy_is_root, cable_power_ok, ev} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cyc_start_data} = '0;
    {phys_node_number, flt_src_node, flt_src_bus} = '0;
    s_axi_wstrb = 4'hF;
    bad_count = 0;
    total_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and an unmapped place
    rd_chk(lnf_pkg::OFS_NODE_ID, 32'h0000_FFFF);
    rd_chk(lnf_pkg::OFS_PHY_ACC, 32'h0000_0000);
    rd_chk(lnf_pkg::OFS_FLO_SET, 32'h0000_0000);
    axr(12'h0F8, d, r);
    chk({d[31:2], r}, {30'h0, lnf_pkg::RESP_SLVERR});
    // Bus number field, read-only bits ignored
    axw(lnf_pkg::OFS_NODE_ID, 32'hFFFF_1234);
    rd_chk(lnf_pkg::OFS_NODE_ID, 32'h0000_123F);
    chk({16'h0, node_id}, 32'h0000_123F);
    // Filters primed, then a bus reset
    axw(lnf_pkg::OFS_FLO_SET, 32'hFFFF_FFFF);
    axw(lnf_pkg::OFS_FHI_SET, 32'h8000_0001);
    rd_chk(lnf_pkg::OFS_FLO_CLR, 32'hFFFF_FFFF);
    cable_power_ok <= 1'b1;
    phy_is_root <= 1'b1;
    phy_bus_reset <= 1'b1;
    repeat (6) @(posedge aclk);
    rd_chk(lnf_pkg::OFS_NODE_ID, 32'h4800_123F);
    rd_chk(lnf_pkg::OFS_FLO_SET, 32'h0000_0000);
    rd_chk(lnf_pkg::OFS_FHI_SET, 32'h8000_0000);
    axw(lnf_pkg::OFS_FLO_SET, 32'h0000_0001);
    rd_chk(lnf_pkg::OFS_FLO_SET, 32'h0000_0000);
    phy_bus_reset <= 1'b0;
    phys_node_number <= 6'h05;
    @(posedge aclk);
    phy_self_id_done <= 1'b1;
    repeat (6) @(posedge aclk);
    phy_self_id_done <= 1'b0;
    rd_chk(lnf_pkg::OFS_NODE_ID, 32'hC800_1205);
    chk({16'h0, node_id}, 32'h0000_1205);
    // Second bus reset drops the valid flag
    phy_bus_reset <= 1'b1;
    repeat (6) @(posedge aclk);
    rd_chk(lnf_pkg::OFS_NODE_ID, 32'h4800_1205);
    phy_bus_reset <= 1'b0;
    // Clear the event flag, enable the timer, then set and clear
    axw(lnf_pkg::OFS_LINK_CTL, 32'h0000_0009);
    axw(lnf_pkg::OFS_FLO_SET, 32'h0000_0021);
    axw(lnf_pkg::OFS_FLO_CLR, 32'h0000_0001);
    rd_chk(lnf_pkg::OFS_FLO_SET, 32'h0000_0020);
    axw(lnf_pkg::OFS_FHI_SET, 32'h0000_0002);
    // Source lookups: own bus, local alias, remote
    qry(10'h048, 6'h05, 1'b1);
    qry(10'h048, 6'h00, 1'b0);
    qry(10'h048, 6'h21, 1'b1);
    qry(10'h048, 6'h22, 1'b0);
    qry(10'h3FF, 6'h05, 1'b1);
    qry(10'h001, 6'h00, 1'b1);
    axw(lnf_pkg::OFS_FHI_CLR, 32'h8000_0000);
    qry(10'h001, 6'h05, 1'b0);
    // PHY register write, read back, completion flag
    axw(lnf_pkg::OFS_PHY_ACC, 32'h0000_43A5);
    poll(32'h0000_4000, 32'h0);
    rd_chk(lnf_pkg::OFS_PHY_ACC, 32'h0000_03A5);
    axw(lnf_pkg::OFS_PHY_ACC, 32'h0000_8300);
    poll(32'h8000_0000, 32'h8000_0000);
    rd_chk(lnf_pkg::OFS_PHY_ACC, 32'h83A5_0300);
    axw(lnf_pkg::OFS_PHY_ACC, 32'h0000_4300);
    rd_chk(lnf_pkg::OFS_PHY_ACC, 32'h03A5_4300);
    poll(32'h0000_4000, 32'h0);
    // Cycle timer wraps
    axw(lnf_pkg::OFS_CYC_TMR, 32'h0000_0BFE);
    pulse(0);
    pulse(0);
    chk(cycle_timer, 32'h0000_1000);
    axw(lnf_pkg::OFS_CYC_TMR, 32'h03F3_FBFF);
    pulse(0);
    chk(cycle_timer, 32'h0400_0000);
    axw(lnf_pkg::OFS_CYC_TMR, 32'hFFF3_FBFF);
    pulse(0);
    chk(cycle_timer, 32'h0000_0000);
    // External reference, cycle start load, master mode
    axw(lnf_pkg::OFS_LINK_CTL, 32'h0000_0005);
    axw(lnf_pkg::OFS_CYC_TMR, 32'h0000_0100);
    pulse(1);
    chk(cycle_timer, 32'h0000_0000);
    cyc_start_data <= 32'h1234_5678;
    pulse(2);
    rd_chk(lnf_pkg::OFS_CYC_TMR, 32'h1234_5678);
    axw(lnf_pkg::OFS_LINK_CTL, 32'h0000_0002);
    cyc_start_data <= 32'h0000_0000;
    pulse(2);
    pulse(0);
    chk(cycle_timer, 32'h1234_5678);
    complete_run();
  end
endmodule
